// File: pkg/pts_pkg.sv
`default_nettype none
package pts_pkg;
  // Bus commands of the basic transaction set
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  // Command bit that marks a write
  localparam int CMD_WR_BIT = 0;

  // Configuration space byte offsets
  localparam logic [7:0] CFG_ID_OFS = 8'h00;
  localparam logic [7:0] CFG_CMD_OFS = 8'h04;
  localparam logic [7:0] CFG_BAR0_OFS = 8'h10;
  localparam logic [7:0] CFG_BAR1_OFS = 8'h14;
  // Identity word; value is arbitrary
  localparam logic [31:0] CFG_ID_VALUE = 32'h0001_0001;
  // Command register fields and reset
  localparam int CFG_CMD_IO_EN = 0;
  localparam int CFG_CMD_MEM_EN = 1;
  localparam logic [31:0] CFG_CMD_RESET = 32'h0000_0000;
  // Base address windows: memory 4 KB, I/O 256 bytes
  localparam logic [31:0] BAR0_MASK = 32'hFFFF_F000;
  localparam logic [31:0] BAR1_MASK = 32'hFFFF_FF00;
  localparam logic [31:0] BAR1_IO_FLAG = 32'h0000_0001;
  localparam logic [31:0] BAR_RESET = 32'h0000_0000;

  // Hit vector bits
  localparam int HIT_MEM = 0;
  localparam int HIT_IO = 1;

  // Consecutive local-ready cycles before trdyn is driven low
  localparam logic [1:0] RD_RDY_CLKS = 2'h2;
  localparam logic [1:0] WR_RDY_CLKS = 2'h1;
  // Data-phase clocks the master waits for devseln
  localparam logic [2:0] MST_ABORT_CLKS = 3'h5;
endpackage
`default_nettype wire

// File: pkg/pts_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pts_bus_if;
  // Per-party drive and enable
  logic [31:0] m_ad_o;
  logic m_ad_oe;
  logic [3:0] m_cben_o;
  logic m_cben_oe;
  logic m_framen_o;
  logic m_framen_oe;
  logic m_irdyn_o;
  logic m_irdyn_oe;
  logic m_idsel_o;
  logic [31:0] t_ad_o;
  logic t_ad_oe;
  logic t_trdyn_o;
  logic t_trdyn_oe;
  logic t_devseln_o;
  logic t_devseln_oe;
  // Resolved wire levels, pulled high when nobody drives
  logic [31:0] ad;
  logic [3:0] cben;
  logic framen;
  logic irdyn;
  logic idsel;
  logic trdyn;
  logic devseln;

  assign ad = t_ad_oe ? t_ad_o : (m_ad_oe ? m_ad_o : 32'hFFFF_FFFF);
  assign cben = m_cben_oe ? m_cben_o : 4'hF;
  assign framen = m_framen_oe ? m_framen_o : 1'b1;
  assign irdyn = m_irdyn_oe ? m_irdyn_o : 1'b1;
  assign idsel = m_idsel_o;
  assign trdyn = t_trdyn_oe ? t_trdyn_o : 1'b1;
  assign devseln = t_devseln_oe ? t_devseln_o : 1'b1;

  modport target (
    input ad, cben, framen, irdyn, idsel,
    output t_ad_o, t_ad_oe, t_trdyn_o, t_trdyn_oe, t_devseln_o, t_devseln_oe
  );
  modport master (
    input ad, trdyn, devseln,
    output m_ad_o, m_ad_oe, m_cben_o, m_cben_oe, m_framen_o, m_framen_oe,
    output m_irdyn_o, m_irdyn_oe, m_idsel_o
  );
endinterface
`default_nettype wire

// File: rtl/pts_master.sv
`timescale 1ns/1ns
`default_nettype none
module pts_master
  import pts_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  pts_bus_if.master bus,
  input wire logic mst_start_in,
  input wire logic [3:0] mst_cmd_in,
  input wire logic [31:0] mst_addr_in,
  input wire logic [3:0] mst_be_n_in,
  input wire logic [31:0] mst_wdata_in,
  input wire logic mst_idsel_in,
  output logic mst_busy_out,
  output logic mst_done_out,
  output logic mst_abort_out,
  output logic [31:0] mst_rdata_out
);
  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_DATA, M_TURN, M_REL} pts_mstate_t;

  pts_mstate_t state_r;
  logic [3:0] cmd_r;
  logic [31:0] addr_r;
  logic [3:0] be_n_r;
  logic [31:0] wdata_r;
  logic idsel_r;
  logic [2:0] wait_cnt_r;
  logic done_r;
  logic abort_r;
  logic [31:0] rdata_r;

  // Sequence: address, single data phase, turn-around, release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= M_IDLE;
    end else begin
      unique case (state_r)
        M_IDLE: if (mst_start_in) state_r <= M_ADDR;
        M_ADDR: state_r <= M_DATA;
        M_DATA: begin
          if (!bus.trdyn || (bus.devseln && wait_cnt_r == MST_ABORT_CLKS)) begin
            state_r <= M_TURN;
          end
        end
        M_TURN: state_r <= M_REL;
        M_REL: state_r <= M_IDLE;
      endcase
    end
  end

  // Request capture
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_r <= 4'h0;
      addr_r <= 32'h0000_0000;
      be_n_r <= 4'hF;
      wdata_r <= 32'h0000_0000;
      idsel_r <= 1'b0;
    end else if (state_r == M_IDLE && mst_start_in) begin
      cmd_r <= mst_cmd_in;
      addr_r <= mst_addr_in;
      be_n_r <= mst_be_n_in;
      wdata_r <= mst_wdata_in;
      idsel_r <= mst_idsel_in;
    end
  end

  // Devsel wait counter for master abort
  always_ff @(posedge clk_in) begin
    if (rst_in || state_r != M_DATA) begin
      wait_cnt_r <= 3'h0;
    end else if (bus.devseln && wait_cnt_r != MST_ABORT_CLKS) begin
      wait_cnt_r <= wait_cnt_r + 3'h1;
    end
  end

  // Completion, abort and read data
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_r <= 1'b0;
      abort_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      done_r <= state_r == M_DATA && !bus.trdyn;
      abort_r <= state_r == M_DATA && bus.trdyn && bus.devseln &&
                 wait_cnt_r == MST_ABORT_CLKS;
      if (state_r == M_DATA && !bus.trdyn && !cmd_r[CMD_WR_BIT]) begin
        rdata_r <= bus.ad;
      end
    end
  end

  // Pin drive: frame/ad/cmd in address clock, byte enables and irdyn after
  always_comb begin
    bus.m_framen_oe = state_r == M_ADDR || state_r == M_DATA;
    bus.m_framen_o = state_r != M_ADDR;
    bus.m_cben_oe = state_r == M_ADDR || state_r == M_DATA;
    bus.m_cben_o = (state_r == M_ADDR) ? cmd_r : be_n_r;
    bus.m_ad_oe = state_r == M_ADDR || (state_r == M_DATA && cmd_r[CMD_WR_BIT]);
    bus.m_ad_o = (state_r == M_ADDR) ? addr_r : wdata_r;
    bus.m_irdyn_oe = state_r == M_DATA || state_r == M_TURN;
    bus.m_irdyn_o = state_r != M_DATA;
    bus.m_idsel_o = state_r == M_ADDR && idsel_r;
  end

  assign mst_busy_out = state_r != M_IDLE;
  assign mst_done_out = done_r;
  assign mst_abort_out = abort_r;
  assign mst_rdata_out = rdata_r;
endmodule
`default_nettype wire

// File: rtl/pts_target.sv
`timescale 1ns/1ns
`default_nettype none
module pts_target
  import pts_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  pts_bus_if.target bus,
  input wire logic local_tgt_ready_n_in,
  input wire logic [31:0] local_tgt_rdata_in,
  output logic local_tgt_xfer_strobe_n_out,
  output logic [31:0] local_tgt_addr_out,
  output logic [3:0] local_tgt_cmd_out,
  output logic local_tgt_access_n_out,
  output logic [1:0] bar_hit_out,
  output logic [31:0] local_tgt_wdata_out
);
  typedef enum logic [2:0] {
    T_IDLE, T_DECODE, T_HIT, T_WAIT, T_DATA, T_TURN, T_END
  } pts_tstate_t;

  pts_tstate_t state_r;
  logic [31:0] addr_r;
  logic [3:0] cmd_r;
  logic idsel_r;
  logic [1:0] hit_r;
  logic access_n_r;
  logic [1:0] rdy_cnt_r;
  logic xfer_n_r;
  logic [31:0] rdata_r;
  logic [31:0] wdata_r;
  logic [31:0] cfg_cmd_r;
  logic [31:0] bar0_r;
  logic [31:0] bar1_r;
  logic is_cfg;
  logic is_wr;
  logic [1:0] hit_nxt;
  logic [1:0] rdy_need;
  logic rdy_done;
  logic ready;

  // Byte-enable merge of a configuration write
  function automatic logic [31:0] merge_be(input logic [31:0] old_val,
                                           input logic [31:0] new_val,
                                           input logic [3:0] be_n);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (!be_n[i]) res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction

  // Commands the target answers
  function automatic logic cmd_supported(input logic [3:0] cmd);
    return cmd == CMD_IO_RD || cmd == CMD_IO_WR || cmd == CMD_MEM_RD ||
           cmd == CMD_MEM_WR || cmd == CMD_CFG_RD || cmd == CMD_CFG_WR;
  endfunction

  assign is_cfg = cmd_r == CMD_CFG_RD || cmd_r == CMD_CFG_WR;
  assign is_wr = cmd_r[CMD_WR_BIT];
  assign ready = !local_tgt_ready_n_in;
  // Same ready count for I/O and memory; only direction differs
  assign rdy_need = is_wr ? WR_RDY_CLKS : RD_RDY_CLKS;
  assign rdy_done = ready && (rdy_cnt_r == rdy_need - 2'h1);

  // Window decode against the base address registers
  always_comb begin
    hit_nxt = 2'b00;
    if ((cmd_r == CMD_MEM_RD || cmd_r == CMD_MEM_WR) && cfg_cmd_r[CFG_CMD_MEM_EN] &&
        (addr_r & BAR0_MASK) == bar0_r) begin
      hit_nxt[HIT_MEM] = 1'b1;
    end
    if ((cmd_r == CMD_IO_RD || cmd_r == CMD_IO_WR) && cfg_cmd_r[CFG_CMD_IO_EN] &&
        (addr_r & BAR1_MASK) == bar1_r) begin
      hit_nxt[HIT_IO] = 1'b1;
    end
  end

  // Transaction sequence
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= T_IDLE;
    end else begin
      unique case (state_r)
        T_IDLE: begin
          // Address clock: frame low, irdyn still high
          if (!bus.framen && bus.irdyn && cmd_supported(bus.cben)) begin
            state_r <= T_DECODE;
          end
        end
        T_DECODE: begin
          if ((is_cfg && idsel_r) || (!is_cfg && hit_nxt != 2'b00)) begin
            state_r <= T_HIT;
          end else begin
            state_r <= T_IDLE;
          end
        end
        T_HIT: state_r <= T_WAIT;
        T_WAIT: begin
          if (is_cfg || rdy_done) state_r <= T_DATA;
        end
        T_DATA: if (!bus.irdyn) state_r <= T_TURN;
        T_TURN: state_r <= T_END;
        T_END: state_r <= T_IDLE;
      endcase
    end
  end

  // Address and command latch, held to the end of the transaction
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_r <= 32'h0000_0000;
      cmd_r <= 4'h0;
      idsel_r <= 1'b0;
    end else if (state_r == T_IDLE && !bus.framen && bus.irdyn) begin
      addr_r <= bus.ad;
      cmd_r <= bus.cben;
      idsel_r <= bus.idsel;
    end
  end

  // Hit and access indication, cleared in the idle clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hit_r <= 2'b00;
      access_n_r <= 1'b1;
    end else if (state_r == T_DECODE && !is_cfg) begin
      hit_r <= hit_nxt;
      access_n_r <= hit_nxt == 2'b00;
    end else if (state_r == T_TURN) begin
      hit_r <= 2'b00;
      access_n_r <= 1'b1;
    end
  end

  // Consecutive local-ready count while waiting
  always_ff @(posedge clk_in) begin
    if (rst_in || state_r != T_WAIT || !ready || is_cfg) begin
      rdy_cnt_r <= 2'h0;
    end else if (rdy_cnt_r != RD_RDY_CLKS) begin
      rdy_cnt_r <= rdy_cnt_r + 2'h1;
    end
  end

  // Local transfer strobe: reads from ready to turn-around, writes in turn-around
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      xfer_n_r <= 1'b1;
    end else if (is_cfg) begin
      xfer_n_r <= 1'b1;
    end else if (!is_wr) begin
      xfer_n_r <= !((state_r == T_WAIT && ready) || state_r == T_DATA);
    end else begin
      xfer_n_r <= !(state_r == T_DATA && !bus.irdyn);
    end
  end

  // Read data: local word while strobed, or configuration word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (state_r == T_WAIT && is_cfg) begin
      unique case (addr_r[7:0])
        CFG_ID_OFS: rdata_r <= CFG_ID_VALUE;
        CFG_CMD_OFS: rdata_r <= cfg_cmd_r;
        CFG_BAR0_OFS: rdata_r <= bar0_r;
        CFG_BAR1_OFS: rdata_r <= bar1_r | BAR1_IO_FLAG;
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else if (state_r == T_WAIT && rdy_done && !is_wr) begin
      rdata_r <= local_tgt_rdata_in;
    end
  end

  // Write data capture and configuration writes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wdata_r <= 32'h0000_0000;
      cfg_cmd_r <= CFG_CMD_RESET;
      bar0_r <= BAR_RESET;
      bar1_r <= BAR_RESET;
    end else if (state_r == T_DATA && !bus.irdyn && is_wr) begin
      if (!is_cfg) begin
        wdata_r <= bus.ad;
      end else if (addr_r[7:0] == CFG_CMD_OFS) begin
        cfg_cmd_r <= merge_be(cfg_cmd_r, bus.ad, bus.cben);
      end else if (addr_r[7:0] == CFG_BAR0_OFS) begin
        bar0_r <= merge_be(bar0_r, bus.ad, bus.cben) & BAR0_MASK;
      end else if (addr_r[7:0] == CFG_BAR1_OFS) begin
        bar1_r <= merge_be(bar1_r, bus.ad, bus.cben) & BAR1_MASK;
      end
    end
  end

  // Bus pins: devseln and trdyn driven wait..turn, high in turn, floated after
  always_comb begin
    bus.t_devseln_oe = state_r == T_WAIT || state_r == T_DATA || state_r == T_TURN;
    bus.t_devseln_o = state_r == T_TURN;
    bus.t_trdyn_oe = bus.t_devseln_oe;
    bus.t_trdyn_o = state_r != T_DATA;
    bus.t_ad_oe = state_r == T_DATA && !is_wr;
    bus.t_ad_o = rdata_r;
  end

  assign local_tgt_xfer_strobe_n_out = xfer_n_r;
  assign local_tgt_addr_out = addr_r;
  assign local_tgt_cmd_out = cmd_r;
  assign local_tgt_access_n_out = access_n_r;
  assign bar_hit_out = hit_r;
  assign local_tgt_wdata_out = wdata_r;
endmodule
`default_nettype wire

// File: bench/pts_props.sv
`timescale 1ns/1ns
`default_nettype none
module pts_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [31:0] ad,
  input wire logic [3:0] cben,
  input wire logic framen,
  input wire logic irdyn,
  input wire logic idsel,
  input wire logic trdyn,
  input wire logic devseln,
  input wire logic t_ad_oe,
  input wire logic t_trdyn_oe,
  input wire logic t_devseln_oe,
  input wire logic local_tgt_ready_n_in,
  input wire logic [31:0] local_tgt_rdata_in,
  input wire logic local_tgt_xfer_strobe_n_out,
  input wire logic [31:0] local_tgt_addr_out,
  input wire logic [3:0] local_tgt_cmd_out,
  input wire logic local_tgt_access_n_out,
  input wire logic [1:0] bar_hit_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Address clock and completed data phase as seen on the wire
  logic start;
  logic xfer;
  logic rd_hit;
  assign start = !framen && irdyn;
  assign xfer = !irdyn && !trdyn;
  assign rd_hit = |bar_hit_out && !local_tgt_cmd_out[0];

  chk_addr_latch: assert property (start |=> local_tgt_addr_out == $past(ad)
    && local_tgt_cmd_out == $past(cben)) else $error("local address or command not latched");
  chk_hit_cause: assert property ($rose(|bar_hit_out) |-> $past(start, 2)
    && !local_tgt_access_n_out) else $error("hit without address clock two back");
  chk_devsel_slow: assert property ($rose(|bar_hit_out) |=> !devseln)
    else $error("devseln not one clock after hit");
  chk_read_latency: assert property ($fell(trdyn) && rd_hit
    |-> $past(!local_tgt_ready_n_in, 1) && $past(!local_tgt_ready_n_in, 2))
    else $error("trdyn without two ready clocks");
  chk_read_data: assert property ($fell(trdyn) && rd_hit
    |-> t_ad_oe && ad == $past(local_tgt_rdata_in)) else $error("read data wrong on ad");
  chk_strobe_follow: assert property ($fell(local_tgt_xfer_strobe_n_out)
    && !local_tgt_cmd_out[0] |-> $past(!local_tgt_ready_n_in)) else $error("strobe early");
  chk_data_release: assert property (xfer |=> trdyn && devseln && t_trdyn_oe
    && t_devseln_oe && !t_ad_oe) else $error("turn-around drive wrong");
  chk_idle_float: assert property (xfer |-> ##2 !t_trdyn_oe && !t_devseln_oe
    && bar_hit_out == 2'h0 && local_tgt_xfer_strobe_n_out) else $error("idle clock wrong");
  chk_local_hold: assert property ($rose(|bar_hit_out) |=> ($stable(local_tgt_addr_out)
    && $stable(local_tgt_cmd_out) && $stable(bar_hit_out))[*3]) else $error("local not held");
  chk_cfg_local: assert property (start && idsel && cben[3:1] == 3'h5 |=>
    (local_tgt_xfer_strobe_n_out && local_tgt_access_n_out)[*6]) else $error("cfg used local");
  chk_mst_release: assert property (xfer |=> irdyn && framen && cben == 4'hF)
    else $error("master did not release");
  chk_mst_data: assert property (start |=> framen && !irdyn)
    else $error("master data clock wrong");
  // Main scenarios reached
  cover property ($fell(trdyn) && rd_hit);
  cover property ($fell(local_tgt_xfer_strobe_n_out));
  cover property (start && idsel);
  cover property ($rose(local_tgt_ready_n_in) && !local_tgt_access_n_out);
endmodule
`default_nettype wire

// File: bench/pci_target_single_read_32_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pci_target_single_read_32_tb;
  import pts_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic mst_start = 1'b0;
  logic [3:0] mst_cmd = 4'h0;
  logic [3:0] mst_be_n = 4'h0;
  logic [31:0] mst_addr = 32'h0;
  logic [31:0] mst_wdata = 32'h0;
  logic mst_idsel = 1'b0;
  logic mst_busy, mst_done, mst_abort, strobe_n, access_n, ab, rdy;
  logic [31:0] mst_rdata, laddr, lwdata, got, bar0_w, bar1_w;
  logic [3:0] lcmd;
  logic [1:0] hit;
  logic ready_n = 1'b1;
  logic [31:0] ldata = 32'h0;
  logic [31:0] data_word = 32'h0;
  logic [7:0] ofs_tab [4] = '{CFG_ID_OFS, CFG_CMD_OFS, CFG_BAR0_OFS, CFG_BAR1_OFS};
  integer seed = 32'he0bb;
  integer miscompares = 0;
  integer total_checks = 0;
  integer wait_cnt = 0;
  integer bk_wait = 0;
  logic bk_drop = 1'b0;
  int i;

  pts_bus_if bus ();
  pts_master pts_master_i (.clk_in(clk_in), .rst_in(rst_in), .bus(bus), .mst_start_in(mst_start),
    .mst_cmd_in(mst_cmd), .mst_addr_in(mst_addr), .mst_be_n_in(mst_be_n),
    .mst_wdata_in(mst_wdata), .mst_idsel_in(mst_idsel), .mst_busy_out(mst_busy),
    .mst_done_out(mst_done), .mst_abort_out(mst_abort), .mst_rdata_out(mst_rdata));
  pts_target pts_target_i (.clk_in(clk_in), .rst_in(rst_in), .bus(bus),
    .local_tgt_ready_n_in(ready_n), .local_tgt_rdata_in(ldata),
    .local_tgt_xfer_strobe_n_out(strobe_n), .local_tgt_addr_out(laddr),
    .local_tgt_cmd_out(lcmd), .local_tgt_access_n_out(access_n), .bar_hit_out(hit),
    .local_tgt_wdata_out(lwdata));
  pts_props pts_props_i (.clk_in(clk_in), .rst_in(rst_in), .ad(bus.ad), .cben(bus.cben),
    .framen(bus.framen), .irdyn(bus.irdyn), .idsel(bus.idsel), .trdyn(bus.trdyn),
    .devseln(bus.devseln), .t_ad_oe(bus.t_ad_oe), .t_trdyn_oe(bus.t_trdyn_oe),
    .t_devseln_oe(bus.t_devseln_oe), .local_tgt_ready_n_in(ready_n),
    .local_tgt_rdata_in(ldata), .local_tgt_xfer_strobe_n_out(strobe_n),
    .local_tgt_addr_out(laddr), .local_tgt_cmd_out(lcmd),
    .local_tgt_access_n_out(access_n), .bar_hit_out(hit));

  // Clock generator
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  // Back-end: ready after a chosen delay, optional one-clock drop
  always @(negedge clk_in) begin
    rdy = access_n === 1'b0 && wait_cnt > bk_wait && !(bk_drop && wait_cnt == bk_wait + 2);
    wait_cnt <= (access_n === 1'b0) ? wait_cnt + 1 : 0;
    ready_n <= !rdy;
    ldata <= (rdy || strobe_n === 1'b0) ? data_word : ~data_word;
  end

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t: flag %b expected %b", $time, g, e);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One bus transaction from the master's user side, bounded wait
  task automatic run(input logic [3:0] c, input logic [31:0] a, input logic sel,
                     input logic [31:0] wd);
    int n;
    @(negedge clk_in);
    mst_cmd = c;
    mst_addr = a;
    mst_idsel = sel;
    mst_wdata = wd;
    mst_be_n = c[0] ? 4'h0 : 4'($random(seed));
    mst_start = 1'b1;
    @(negedge clk_in);
    mst_start = 1'b0;
    n = 0;
    while (mst_done !== 1'b1 && mst_abort !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 40) begin
      miscompares++;
      $display("ERROR %0t: transfer hung", $time);
      complete_run();
    end
    got = mst_rdata;
    ab = mst_abort;
    repeat (6) @(negedge clk_in);
    chk1(mst_busy, 1'b0);
  endtask

  // Expected configuration read value
  function automatic logic [31:0] exp_cfg(input logic [7:0] ofs);
    case (ofs)
      CFG_ID_OFS: return CFG_ID_VALUE;
      CFG_CMD_OFS: return 32'h0000_0003;
      CFG_BAR0_OFS: return bar0_w & BAR0_MASK;
      default: return (bar1_w & BAR1_MASK) | BAR1_IO_FLAG;
    endcase
  endfunction

  // Main sequence
  initial begin
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    run(CMD_CFG_RD, {24'h0, CFG_CMD_OFS}, 1'b1, 32'h0);
    chk32(got, CFG_CMD_RESET);
    run(CMD_MEM_RD, 32'h0, 1'b0, 32'h0);
    chk1(ab, 1'b1);
    bar0_w = $random(seed);
    bar1_w = $random(seed);
    run(CMD_CFG_WR, {24'h0, CFG_BAR0_OFS}, 1'b1, bar0_w);
    chk1(ab, 1'b0);
    run(CMD_CFG_WR, {24'h0, CFG_BAR1_OFS}, 1'b1, bar1_w);
    run(CMD_CFG_WR, {24'h0, CFG_CMD_OFS}, 1'b1, 32'h0000_0003);
    for (i = 0; i < 4; i++) begin
      run(CMD_CFG_RD, {24'h0, ofs_tab[i]}, 1'b1, 32'h0);
      chk32(got, exp_cfg(ofs_tab[i]));
    end
    // Unmapped configuration offset reads as zero
    run(CMD_CFG_RD, {24'h0, 8'h08}, 1'b1, 32'h0);
    chk32(got, 32'h0000_0000);
    // Memory and I/O reads, zero wait first, then random waits; every third read from the second has a drop
    for (i = 0; i < 16; i++) begin
      data_word = $random(seed);
      bk_wait = (i < 4) ? 0 : {$random(seed)} % 4;
      bk_drop = (i % 3 == 1);
      if (i % 4 == 3) begin
        run(CMD_IO_RD, (bar1_w & BAR1_MASK) | ({$random(seed)} & 32'hFC), 1'b0, 32'h0);
      end else begin
        run(CMD_MEM_RD, (bar0_w & BAR0_MASK) | ({$random(seed)} & 32'hFFC), 1'b0, 32'h0);
      end
      chk1(ab, 1'b0);
      chk32(got, data_word);
    end
    data_word = $random(seed);
    run(CMD_MEM_WR, bar0_w & BAR0_MASK, 1'b0, data_word);
    chk1(ab, 1'b0);
    chk32(lwdata, data_word);
    data_word = $random(seed);
    run(CMD_IO_WR, bar1_w & BAR1_MASK, 1'b0, data_word);
    chk1(ab, 1'b0);
    chk32(lwdata, data_word);
    // Misses: outside window, unsupported command, config without select
    run(CMD_MEM_RD, (bar0_w & BAR0_MASK) ^ 32'h8000_0000, 1'b0, 32'h0);
    chk1(ab, 1'b1);
    run(4'h0, bar0_w & BAR0_MASK, 1'b0, 32'h0);
    chk1(ab, 1'b1);
    run(CMD_CFG_RD, {24'h0, CFG_ID_OFS}, 1'b0, 32'h0);
    chk1(ab, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
